// ==== pkg/memsync_pkg.sv ====
// Purpose: shared constants for the memory sync and reservation block
// Assumes: 32-bit effective addresses, one operation in flight at a time
// Notes: op codes are the issue-side encoding of this block
`default_nettype none

package memsync_pkg;

   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int DEST_W = 5;
   localparam int OP_W = 4;

   // reservation granule is 32 bytes, so the low five bits are dropped
   localparam int GRANULE_LSB = 5;
   localparam int GRANULE_W = ADDR_W - GRANULE_LSB;
   localparam int ALIGN_BITS = 2;

   typedef logic [OP_W-1:0] op_code_t;
   localparam op_code_t OP_NONE = 4'h0;
   localparam op_code_t OP_SYNC = 4'h1;
   localparam op_code_t OP_EIEIO = 4'h2;
   localparam op_code_t OP_ISYNC = 4'h3;
   localparam op_code_t OP_LWARX = 4'h4;
   localparam op_code_t OP_STWCX = 4'h5;
   localparam op_code_t OP_SYSCALL = 4'h6;
   localparam op_code_t OP_LOAD = 4'h7;
   localparam op_code_t OP_STORE = 4'h8;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_DRAIN = 5'h02,
      ST_BCAST = 5'h04,
      ST_FETCH = 5'h08,
      ST_BUS = 5'h10
   } state_t;

   localparam logic RESV_RESET = 1'b0;
   localparam logic [GRANULE_W-1:0] GRANULE_RESET = 27'h0000000;
   localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h00000000;

   function automatic logic [GRANULE_W-1:0] granule_of(
      input logic [ADDR_W-1:0] addr);
      granule_of = addr[ADDR_W-1:GRANULE_LSB];
   endfunction : granule_of

   function automatic logic is_aligned(input logic [ADDR_W-1:0] addr);
      is_aligned = (addr[ALIGN_BITS-1:0] == 2'h0);
   endfunction : is_aligned

endpackage : memsync_pkg

`default_nettype wire

// ==== src/reset_release.sv ====
// Purpose: two-stage release of the asynchronous reset
// Assumes: arst_n may fall at any time
// Notes: assertion is immediate, release follows two clock edges
`default_nettype none

module reset_release (
   input wire logic clock,
   input wire logic arst_n,
   output logic rst_n
);
   import memsync_pkg::*;

   logic meta_reg;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         meta_reg <= 1'b1;
         rst_n <= meta_reg;
      end
   end

endmodule : reset_release

`default_nettype wire

// ==== src/resv_tracker.sv ====
// Purpose: holds the single reservation and its 32-byte granule
// Assumes: set and clr are one-cycle pulses from the control logic
// Notes: a set in the same cycle as any clear wins
`default_nettype none

module resv_tracker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic set,
   input wire logic [memsync_pkg::ADDR_W-1:0] set_addr,
   input wire logic clr,
   input wire logic snoop_valid,
   input wire logic snoop_write,
   input wire logic [memsync_pkg::ADDR_W-1:0] snoop_addr,
   input wire logic snoop_lost,
   output logic held,
   output logic [memsync_pkg::GRANULE_W-1:0] granule
);
   import memsync_pkg::*;

   logic snoop_hit;

   // another master writing anywhere in the granule breaks it
   assign snoop_hit = snoop_valid && snoop_write &&
                      (granule_of(snoop_addr) == granule);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         held <= RESV_RESET;
      end else if (set) begin
         held <= 1'b1;
      end else if (clr || snoop_hit || snoop_lost) begin
         held <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         granule <= GRANULE_RESET;
      end else if (set) begin
         granule <= granule_of(set_addr);
      end
   end

endmodule : resv_tracker

`default_nettype wire

// ==== src/memory_sync_reservation.sv ====
// Purpose: memory ordering barriers and load-reserve/store-conditional
// Assumes: one operation accepted at a time over op_valid/op_ready
// Notes: the external bus handshake is ext_req held until ext_ack
`default_nettype none

module memory_sync_reservation (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic op_valid,
   input wire memsync_pkg::op_code_t op_code,
   input wire logic [memsync_pkg::ADDR_W-1:0] op_addr,
   input wire logic [memsync_pkg::DATA_W-1:0] op_wdata,
   input wire logic [memsync_pkg::DEST_W-1:0] op_dest,
   output logic op_ready,
   input wire logic older_done,
   input wire logic mem_performed,
   input wire logic ldst_idle,
   input wire logic prefetch_empty,
   input wire logic exc_raise,
   input wire logic async_exc,
   output logic hold_issue,
   output logic hold_ldst,
   output logic hold_fetch,
   output logic ext_req,
   output logic ext_write,
   output logic ext_resv,
   output logic ext_bcast,
   output logic [memsync_pkg::ADDR_W-1:0] ext_addr,
   output logic [memsync_pkg::DATA_W-1:0] ext_wdata,
   input wire logic ext_ack,
   input wire logic [memsync_pkg::DATA_W-1:0] ext_rdata,
   input wire logic snoop_valid,
   input wire logic snoop_write,
   input wire logic [memsync_pkg::ADDR_W-1:0] snoop_addr,
   input wire logic snoop_lost,
   output logic wb_valid,
   output logic [memsync_pkg::DEST_W-1:0] wb_dest,
   output logic [memsync_pkg::DATA_W-1:0] wb_data,
   output logic flag_valid,
   output logic flag_success,
   output logic stwcx_blocked,
   output logic align_exc,
   output logic resv_held
);
   import memsync_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // reset and declarations

   logic rst_n;
   state_t state_reg;
   state_t state_next;
   op_code_t kind_reg;
   logic take;
   logic bus_done;
   logic drain_ok;
   logic resv_set;
   logic resv_clr;
   logic [GRANULE_W-1:0] resv_granule;

   reset_release u_reset (
      .clock(clock),
      .arst_n(arst_n),
      .rst_n(rst_n)
   );

   assign take = op_valid && op_ready;
   assign bus_done = ext_req && ext_ack;

   ////////////////////////////////////////////////////////////////////
   // reservation

   // only an aligned lwarx that completes on the bus sets it
   assign resv_set = (state_reg == ST_BUS) && bus_done &&
                     (kind_reg == OP_LWARX);

   always_comb begin
      resv_clr = 1'b0;
      if (exc_raise) begin
         resv_clr = 1'b1;
      end
      if (async_exc) begin
         resv_clr = 1'b1;
      end
      if (take && op_code == OP_STWCX) begin
         resv_clr = 1'b1;
      end
      if (take && op_code == OP_SYSCALL) begin
         resv_clr = 1'b1;
      end
      if (take && op_code == OP_LWARX && !is_aligned(op_addr)) begin
         resv_clr = 1'b1;
      end
   end

   resv_tracker u_resv (
      .clock(clock),
      .rst_n(rst_n),
      .set(resv_set),
      .set_addr(ext_addr),
      .clr(resv_clr),
      .snoop_valid(snoop_valid),
      .snoop_write(snoop_write),
      .snoop_addr(snoop_addr),
      .snoop_lost(snoop_lost),
      .held(resv_held),
      .granule(resv_granule)
   );

   ////////////////////////////////////////////////////////////////////
   // sequencing

   // sync waits on the whole core, eieio only on loads and stores
   always_comb begin
      if (kind_reg == OP_SYNC) begin
         drain_ok = older_done && mem_performed && ldst_idle;
      end else begin
         drain_ok = ldst_idle;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (take) begin
               case (op_code)
                  OP_SYNC, OP_EIEIO: state_next = ST_DRAIN;
                  OP_ISYNC: state_next = ST_FETCH;
                  OP_LWARX: begin
                     if (is_aligned(op_addr)) begin
                        state_next = ST_BUS;
                     end
                  end
                  OP_STWCX: begin
                     // the granule is not compared here on purpose
                     if (resv_held) begin
                        state_next = ST_BUS;
                     end
                  end
                  OP_LOAD, OP_STORE: state_next = ST_BUS;
                  default: state_next = ST_IDLE;
               endcase
            end
         end
         ST_DRAIN: begin
            if (drain_ok) begin
               state_next = ST_BCAST;
            end
         end
         ST_BCAST: begin
            if (bus_done) begin
               state_next = ST_IDLE;
            end
         end
         ST_FETCH: begin
            if (older_done && prefetch_empty) begin
               state_next = ST_IDLE;
            end
         end
         ST_BUS: begin
            if (bus_done) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         kind_reg <= OP_NONE;
      end else if (take) begin
         kind_reg <= op_code;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         op_ready <= 1'b0;
      end else begin
         op_ready <= (state_next == ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // stall outputs

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hold_issue <= 1'b0;
      end else if (take && op_code == OP_SYNC) begin
         hold_issue <= 1'b1;
      end else if (state_next == ST_IDLE) begin
         hold_issue <= 1'b0;
      end
   end

   // a sync also orders memory, so it holds loads and stores as well
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hold_ldst <= 1'b0;
      end else if (take && (op_code == OP_EIEIO ||
                            op_code == OP_SYNC)) begin
         hold_ldst <= 1'b1;
      end else if (state_next == ST_IDLE) begin
         hold_ldst <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hold_fetch <= 1'b0;
      end else if (take && op_code == OP_ISYNC) begin
         hold_fetch <= 1'b1;
      end else if (state_next == ST_IDLE) begin
         hold_fetch <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // external bus cycle

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ext_req <= 1'b0;
      end else begin
         ext_req <= (state_next == ST_BUS) ||
                    (state_next == ST_BCAST);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ext_bcast <= 1'b0;
      end else begin
         ext_bcast <= (state_next == ST_BCAST);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ext_write <= 1'b0;
         ext_resv <= 1'b0;
      end else if (take) begin
         ext_write <= (op_code == OP_STWCX) || (op_code == OP_STORE);
         ext_resv <= (op_code == OP_LWARX) ||
                     (op_code == OP_STWCX);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ext_addr <= ADDR_RESET;
         ext_wdata <= DATA_RESET;
      end else if (take) begin
         ext_addr <= op_addr;
         ext_wdata <= op_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // results

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wb_dest <= 5'h00;
      end else if (take) begin
         wb_dest <= op_dest;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wb_valid <= 1'b0;
         wb_data <= DATA_RESET;
      end else begin
         wb_valid <= (state_reg == ST_BUS) && bus_done &&
                     (kind_reg == OP_LWARX || kind_reg == OP_LOAD);
         if ((state_reg == ST_BUS) && bus_done) begin
            wb_data <= ext_rdata;
         end
      end
   end

   // success bit: one after the store lands, zero at once if none held
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag_valid <= 1'b0;
         flag_success <= 1'b0;
      end else if ((state_reg == ST_BUS) && bus_done &&
                   (kind_reg == OP_STWCX)) begin
         flag_valid <= 1'b1;
         flag_success <= 1'b1;
      end else if (take && op_code == OP_STWCX && !resv_held) begin
         flag_valid <= 1'b1;
         flag_success <= 1'b0;
      end else begin
         flag_valid <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stwcx_blocked <= 1'b0;
      end else begin
         stwcx_blocked <= take && (op_code == OP_STWCX) &&
                          !resv_held;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         align_exc <= 1'b0;
      end else begin
         align_exc <= take && (op_code == OP_LWARX) &&
                      !is_aligned(op_addr);
      end
   end

endmodule : memory_sync_reservation

`default_nettype wire

// ==== tb/msr_chk.sv ====
// Purpose: port assertions for the memory sync and reservation block
// Assumes: one op in flight, bus cycle held until ext_ack
// Notes: bound onto the top module below
`default_nettype none

module msr_chk (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic op_valid,
   input wire memsync_pkg::op_code_t op_code,
   input wire logic [31:0] op_addr,
   input wire logic op_ready,
   input wire logic older_done,
   input wire logic mem_performed,
   input wire logic ldst_idle,
   input wire logic prefetch_empty,
   input wire logic exc_raise,
   input wire logic async_exc,
   input wire logic snoop_lost,
   input wire logic hold_issue,
   input wire logic hold_ldst,
   input wire logic hold_fetch,
   input wire logic ext_req,
   input wire logic ext_write,
   input wire logic ext_resv,
   input wire logic ext_bcast,
   input wire logic [31:0] ext_addr,
   input wire logic ext_ack,
   input wire logic [31:0] ext_rdata,
   input wire logic wb_valid,
   input wire logic [31:0] wb_data,
   input wire logic flag_valid,
   input wire logic flag_success,
   input wire logic stwcx_blocked,
   input wire logic align_exc,
   input wire logic resv_held
);
   timeunit 1ns;
   timeprecision 1ns;
   import memsync_pkg::*;
   wire logic tk;
   wire logic fin;
   assign tk = op_valid && op_ready;
   assign fin = ext_req && ext_ack;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////
   property p_sync;
      tk && op_code == OP_SYNC |=> hold_issue && hold_ldst && !op_ready;
   endproperty
   a_sync: assert property (p_sync)
      else $error("sync did not stall issue");
   property p_drain;
      $rose(ext_bcast) && hold_issue |->
         $past(older_done && mem_performed && ldst_idle);
   endproperty
   a_drain: assert property (p_drain)
      else $error("broadcast before drain");
   property p_eieio;
      tk && op_code == OP_EIEIO |=> hold_ldst && !hold_issue;
   endproperty
   a_eieio: assert property (p_eieio)
      else $error("barrier did not hold loads");
   property p_fetch;
      hold_fetch && !(older_done && prefetch_empty) |=> hold_fetch;
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("fetch released early");
   property p_rcyc;
      tk && op_code == OP_LWARX && op_addr[1:0] == 2'h0 |=> ext_req &&
         ext_resv && !ext_write && ext_addr == $past(op_addr);
   endproperty
   a_rcyc: assert property (p_rcyc)
      else $error("reserve cycle wrong");
   property p_rset;
      fin && ext_resv && !ext_write |=>
         resv_held && wb_valid && wb_data == $past(ext_rdata);
   endproperty
   a_rset: assert property (p_rset)
      else $error("reserve load result wrong");
   property p_scclr;
      tk && op_code == OP_STWCX |=> !resv_held;
   endproperty
   a_scclr: assert property (p_scclr)
      else $error("conditional store kept reservation");
   property p_scfail;
      tk && op_code == OP_STWCX && !resv_held |=>
         flag_valid && !flag_success && stwcx_blocked && !ext_req;
   endproperty
   a_scfail: assert property (p_scfail)
      else $error("unreserved store not refused");
   property p_scok;
      fin && ext_write && ext_resv |=> flag_valid && flag_success;
   endproperty
   a_scok: assert property (p_scok)
      else $error("reserved store not reported");
   property p_align;
      tk && op_code == OP_LWARX && op_addr[1:0] != 2'h0 |=>
         align_exc && !ext_req && !resv_held;
   endproperty
   a_align: assert property (p_align)
      else $error("misaligned reserve not trapped");
   property p_lose;
      (exc_raise || async_exc || snoop_lost) && !fin |=> !resv_held;
   endproperty
   a_lose: assert property (p_lose)
      else $error("reservation survived a clear");
   c_rset: cover property (fin && ext_resv && !ext_write);
   c_scok: cover property (fin && ext_write && ext_resv);
   c_bcast: cover property (fin && ext_bcast);
endmodule : msr_chk

bind memory_sync_reservation msr_chk msr_chk_inst (.clock, .arst_n,
   .op_valid, .op_code, .op_addr, .op_ready, .older_done, .mem_performed,
   .ldst_idle, .prefetch_empty, .exc_raise, .async_exc, .snoop_lost,
   .hold_issue, .hold_ldst, .hold_fetch, .ext_req, .ext_write, .ext_resv,
   .ext_bcast, .ext_addr, .ext_ack, .ext_rdata, .wb_valid, .wb_data,
   .flag_valid, .flag_success, .stwcx_blocked, .align_exc, .resv_held);

`default_nettype wire

// ==== tb/ext_bus_model.sv ====
// Purpose: far-side bus responder with a small word memory
// Assumes: ext_req held until ext_ack, one cycle in flight
// Notes: lat sets the wait before each ack
`default_nettype none

module ext_bus_model (
   input wire logic clock,
   input wire logic ext_req,
   input wire logic ext_write,
   input wire logic [31:0] ext_addr,
   input wire logic [31:0] ext_wdata,
   input wire logic [7:0] lat,
   output var logic ext_ack,
   output var logic [31:0] ext_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [0:15];
   logic [7:0] cnt_reg = 8'h00;
   initial begin
      ext_ack = 1'b0;
      ext_rdata = 32'h00000000;
      for (int i = 0; i < 16; i++) mem[i] = 32'hC0DE0000 | 32'(i);
   end
   ////////////////////////////////////////////////////////////////////////
   // data toggles off the ack so a stale word never passes as fresh
   always @(posedge clock) begin
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
      if (ext_req && !ext_ack) begin
         if (cnt_reg >= lat) begin
            ext_ack <= 1'b1;
            cnt_reg <= 8'h00;
            ext_rdata <= mem[ext_addr[5:2]];
            if (ext_write) mem[ext_addr[5:2]] <= ext_wdata;
         end else begin
            cnt_reg <= cnt_reg + 8'h01;
         end
      end
   end
endmodule : ext_bus_model

`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the memory sync block
// Assumes: far bus answered by ext_bus_model
// Notes: each scenario waits on op_ready under a bound
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import memsync_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic op_valid, older_done, mem_performed, ldst_idle, prefetch_empty;
   logic exc_raise, async_exc, snoop_valid, snoop_write, snoop_lost;
   op_code_t op_code;
   logic [31:0] op_addr, op_wdata, snoop_addr, ext_addr, ext_wdata;
   logic [31:0] ext_rdata, wb_data, wb_seen;
   logic [4:0] op_dest, wb_dest, dest_seen;
   logic op_ready, hold_issue, hold_ldst, hold_fetch, ext_req, ext_write;
   logic ext_resv, ext_bcast, ext_ack, wb_valid, flag_valid, flag_success;
   logic stwcx_blocked, align_exc, resv_held;
   logic [1:0] flag_seen;
   logic [7:0] lat;
   int error_cnt = 0;
   int checked = 0;
   int al_cnt = 0;

   always #20 clock = ~clock;

   memory_sync_reservation memory_sync_reservation_inst (.clock, .arst_n,
      .op_valid, .op_code, .op_addr, .op_wdata, .op_dest, .op_ready,
      .older_done, .mem_performed, .ldst_idle, .prefetch_empty, .exc_raise,
      .async_exc, .hold_issue, .hold_ldst, .hold_fetch, .ext_req,
      .ext_write, .ext_resv, .ext_bcast, .ext_addr, .ext_wdata, .ext_ack,
      .ext_rdata, .snoop_valid, .snoop_write, .snoop_addr, .snoop_lost,
      .wb_valid, .wb_dest, .wb_data, .flag_valid, .flag_success,
      .stwcx_blocked, .align_exc, .resv_held);
   ext_bus_model ext_bus_model_inst (.clock, .ext_req, .ext_write,
      .ext_addr, .ext_wdata, .lat, .ext_ack, .ext_rdata);

   // result pulses last one cycle, so latch them here
   always @(posedge clock) begin
      if (wb_valid === 1'b1) begin
         wb_seen <= wb_data;
         dest_seen <= wb_dest;
      end
      if (flag_valid === 1'b1) flag_seen <= {stwcx_blocked, flag_success};
      if (align_exc === 1'b1) al_cnt <= al_cnt + 1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      $display("checked=%0d errors=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   task automatic await_ready;
      int n;
      n = 0;
      @(posedge clock);
      while (op_ready !== 1'b1) begin
         n++;
         if (n > 500) begin
            error_cnt++;
            close_out;
         end
         @(posedge clock);
      end
   endtask : await_ready

   task automatic offer(input op_code_t c, input logic [31:0] addr);
      op_valid <= 1'b1;
      op_code <= c;
      op_addr <= addr;
      op_wdata <= ~addr;
      op_dest <= addr[6:2];
      await_ready;
      op_valid <= 1'b0;
   endtask : offer

   task automatic issue(input op_code_t c, input logic [31:0] addr);
      offer(c, addr);
      await_ready;
      @(posedge clock);
   endtask : issue

   task automatic snoop(input logic [31:0] a, input logic w);
      snoop_valid <= 1'b1;
      snoop_write <= w;
      snoop_addr <= a;
      @(posedge clock);
      snoop_valid <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : snoop
   ////////////////////////////////////////////////////////////////////////
   task automatic s_fresh;
      check(resv_held, 0);
      issue(OP_STWCX, 32'h00000010);
      check(flag_seen, 2'h2);
      check(ext_bus_model_inst.mem[4], 32'hC0DE0004);
   endtask : s_fresh

   task automatic s_pair;
      lat <= 8'h03;
      issue(OP_LWARX, 32'h00000024);
      check(wb_seen, 32'hC0DE0009);
      check(dest_seen, 5'h09);
      check(resv_held, 1);
      issue(OP_STWCX, 32'h00000008);
      check(flag_seen, 2'h1);
      check(ext_bus_model_inst.mem[2], 32'hFFFFFFF7);
      check(resv_held, 0);
      issue(OP_STWCX, 32'h00000024);
      check(flag_seen, 2'h2);
      lat <= 8'h00;
   endtask : s_pair

   task automatic s_granule;
      issue(OP_LWARX, 32'h00000000);
      issue(OP_LWARX, 32'h00000044);
      snoop(32'h0000001C, 1'b1);
      check(resv_held, 1);
      snoop(32'h0000005C, 1'b0);
      snoop(32'h00000060, 1'b1);
      check(resv_held, 1);
      snoop(32'h0000005C, 1'b1);
      check(resv_held, 0);
   endtask : s_granule

   // plain loads and stores neither make nor break a reservation
   task automatic s_plain;
      issue(OP_LOAD, 32'h0000000C);
      check(wb_seen, 32'hC0DE0003);
      check(resv_held, 0);
      issue(OP_LWARX, 32'h00000040);
      issue(OP_STORE, 32'h0000000C);
      check(ext_bus_model_inst.mem[3], 32'hFFFFFFF3);
      check(resv_held, 1);
   endtask : s_plain

   task automatic s_clear;
      for (int k = 0; k < 5; k++) begin
         issue(OP_LWARX, 32'h00000030);
         if (k == 0) begin
            issue(OP_SYSCALL, 32'h00000000);
         end else if (k == 4) begin
            issue(OP_LWARX, 32'h00000032);
         end else begin
            exc_raise <= (k == 1);
            async_exc <= (k == 2);
            snoop_lost <= (k == 3);
            @(posedge clock);
            {exc_raise, async_exc, snoop_lost} <= 3'h0;
            repeat (2) @(posedge clock);
         end
         check(resv_held, 0);
      end
      check(al_cnt, 1);
   endtask : s_clear

   // one input of its own left low must be enough to stall each barrier
   task automatic s_barrier(input op_code_t c, input logic [2:0] hexp,
      input logic [3:0] stall);
      {older_done, mem_performed, ldst_idle, prefetch_empty} <= stall;
      offer(c, 32'h00000000);
      repeat (4) @(posedge clock);
      check({hold_issue, hold_ldst, hold_fetch}, hexp);
      check(ext_req, 0);
      {older_done, mem_performed, ldst_idle, prefetch_empty} <= 4'hF;
      await_ready;
      @(posedge clock);
      check({hold_issue, hold_ldst, hold_fetch}, 0);
   endtask : s_barrier
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {op_valid, exc_raise, async_exc, snoop_valid, snoop_write} = 5'h00;
      {older_done, mem_performed, ldst_idle, prefetch_empty} = 4'hF;
      snoop_lost = 1'b0;
      op_code = OP_NONE;
      op_addr = 32'h00000000;
      op_wdata = 32'h00000000;
      op_dest = 5'h00;
      snoop_addr = 32'h00000000;
      lat = 8'h00;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      await_ready;
      s_fresh;
      s_pair;
      s_granule;
      s_plain;
      s_clear;
      s_barrier(OP_SYNC, 3'h6, 4'hB);
      s_barrier(OP_EIEIO, 3'h2, 4'hD);
      s_barrier(OP_ISYNC, 3'h1, 4'hE);
      close_out;
   end
endmodule : tb_top

`default_nettype wire
